/* File: verilog/pswr_pkg.sv */
// constants of the pyro sensor single wire readout block
// What this block does
// - packet is second channel [41:28], first channel [27:14], temperature [13:0].
// - all three values are unsigned 14-bit; channels are low-pass filtered upstream.
// - channel below 511 or above full scale minus 511 shorts input about 16 ms.
// - a low to high line transition starts any transfer, from either side.
// - no host start for longer than 14.6 ms makes the device drive high.
// - without host starts the device raises a request periodically, after 14.6 ms in idle.
// - host makes a rising edge per bit; device waits for it before presenting.
// - after each host rising edge device pulls low for zero, leaves high for one.
// - line low for 145 us at any bit aborts the packet.
package pswr_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_BITS = 14;
   localparam int PACKET_BITS = 42;
   localparam int SECOND_LSB = 28;
   localparam int FIRST_LSB = 14;
   localparam int TEMP_LSB = 0;
   localparam logic [13:0] RANGE_MARGIN = 14'h01ff;
   localparam logic [13:0] RANGE_LOW = RANGE_MARGIN;
   localparam logic [13:0] RANGE_HIGH = 14'h3fff - RANGE_MARGIN;
   // times in their own unit
   localparam int START_HOLD_HIGH_TIME_NS = 110000;
   localparam int SAMPLE_PERIOD_NS = 14600000;
   localparam int DISCHARGE_TIME_NS = 16000000;
   localparam int ABORT_LOW_TIME_NS = 145000;
   localparam int BIT_SETTLE_TIME_NS = 2000;
   localparam int REQ_DRIVE_TIME_NS = 200;
   // derived cycle counts; least times round up, longest round down
   localparam int START_HOLD_CYC = (START_HOLD_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DISCHARGE_CYC = DISCHARGE_TIME_NS / CLK_PERIOD_NS;
   localparam int ABORT_LOW_CYC = (ABORT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_SETTLE_CYC = (BIT_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_DRIVE_CYC = (REQ_DRIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   localparam logic [5:0] LAST_BIT = 6'h29;
   typedef enum logic [5:0] {
      PSWR_IDLE    = 6'h01,
      PSWR_HSTART  = 6'h02,
      PSWR_REQ     = 6'h04,
      PSWR_WAITLOW = 6'h08,
      PSWR_SHIFT   = 6'h10,
      PSWR_TAIL    = 6'h20
   } pswr_state_t;
endpackage

/* File: verilog/pswr_discharge.sv */
// out-of-range detector and discharge timer for one channel
`timescale 1ns/1ps
module pswr_discharge #(
   parameter int DISCHARGE_CYC = pswr_pkg::DISCHARGE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // sample in
   input wire logic sample_valid,
   input wire logic [13:0] sample,
   // discharge switch
   output logic short_input
);
   logic [pswr_pkg::CNT_W-1:0] cnt;
   wire out_of_range = (sample < pswr_pkg::RANGE_LOW) || (sample > pswr_pkg::RANGE_HIGH);
   wire trigger = sample_valid && out_of_range;
   wire [pswr_pkg::CNT_W-1:0] dis_cyc = pswr_pkg::CNT_W'(DISCHARGE_CYC);
   wire at_end = (cnt == dis_cyc - 1'b1);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt <= '0;
         short_input <= 1'b0;
      end else if (ce) begin
         // a fresh trigger restarts the window so the element gets a full discharge
         if (trigger) begin
            cnt <= '0;
            short_input <= 1'b1;
         end else if (short_input) begin
            cnt <= cnt + 1'b1;
            if (at_end) begin
               short_input <= 1'b0;
            end
         end
      end
   end

   property p_short_on;
      @(posedge clk) disable iff (!nrst) (ce && trigger) |=> short_input;
   endproperty
   a_short_on: assert property (p_short_on) else $error("discharge did not start");

   property p_short_end;
      @(posedge clk) disable iff (!nrst)
         (ce && short_input && at_end && !trigger) |=> !short_input;
   endproperty
   a_short_end: assert property (p_short_end) else $error("discharge did not end");
endmodule

/* File: verilog/pswr_top.sv */
// device end of the pyro sensor single wire readout link
`timescale 1ns/1ps
module pswr_top #(
   parameter int START_HOLD_CYC = pswr_pkg::START_HOLD_CYC,
   parameter int SAMPLE_PERIOD_CYC = pswr_pkg::SAMPLE_PERIOD_CYC,
   parameter int ABORT_LOW_CYC = pswr_pkg::ABORT_LOW_CYC,
   parameter int DISCHARGE_CYC = pswr_pkg::DISCHARGE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // filtered samples from the converter
   input wire logic sample_valid,
   input wire logic [13:0] first_channel,
   input wire logic [13:0] second_channel,
   input wire logic [13:0] temperature,
   // shared line, enable low while driving
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n,
   // discharge switches, index 0 first channel
   output logic [1:0] short_input,
   // status
   output logic busy
);
   pswr_pkg::pswr_state_t state, next_state;
   logic [pswr_pkg::CNT_W-1:0] cnt;
   logic [pswr_pkg::CNT_W-1:0] low_cnt;
   logic [pswr_pkg::CNT_W-1:0] drive_cnt;
   logic [5:0] idx;
   logic [pswr_pkg::PACKET_BITS-1:0] packet;
   logic [13:0] first_hold, second_hold, temp_hold;
   logic line_q;

   wire rise = line_in && !line_q;
   wire [pswr_pkg::CNT_W-1:0] start_cyc = pswr_pkg::CNT_W'(START_HOLD_CYC);
   wire [pswr_pkg::CNT_W-1:0] period_cyc = pswr_pkg::CNT_W'(SAMPLE_PERIOD_CYC);
   wire [pswr_pkg::CNT_W-1:0] abort_cyc = pswr_pkg::CNT_W'(ABORT_LOW_CYC);
   wire [pswr_pkg::CNT_W-1:0] settle_cyc = pswr_pkg::CNT_W'(pswr_pkg::BIT_SETTLE_CYC);
   wire [pswr_pkg::CNT_W-1:0] req_cyc = pswr_pkg::CNT_W'(pswr_pkg::REQ_DRIVE_CYC);
   wire timeout = (cnt >= period_cyc - 1'b1);
   wire start_long = (cnt >= start_cyc - 1'b1);
   wire abort = !line_in && (low_cnt >= abort_cyc - 1'b1);
   wire driving = !line_oe_n;
   wire cur_bit = packet[idx];
   wire last_bit = (idx == 6'h00);
   wire [pswr_pkg::PACKET_BITS-1:0] snapshot = {second_hold, first_hold, temp_hold};
   wire enter_shift = (next_state == pswr_pkg::PSWR_SHIFT) && (state != pswr_pkg::PSWR_SHIFT);

   // next state; a start counts only if the line stays high for the start hold time before it falls
   always_comb begin
      next_state = state;
      case (state)
         pswr_pkg::PSWR_IDLE: begin
            if (rise) next_state = pswr_pkg::PSWR_HSTART;
            else if (timeout) next_state = pswr_pkg::PSWR_REQ;
         end
         pswr_pkg::PSWR_HSTART: begin
            if (!line_in) next_state = start_long ? pswr_pkg::PSWR_SHIFT : pswr_pkg::PSWR_IDLE;
         end
         pswr_pkg::PSWR_REQ: begin
            if (cnt >= req_cyc - 1'b1) next_state = pswr_pkg::PSWR_WAITLOW;
         end
         pswr_pkg::PSWR_WAITLOW: begin
            if (!line_in) next_state = pswr_pkg::PSWR_SHIFT;
         end
         pswr_pkg::PSWR_SHIFT: begin
            if (abort) next_state = pswr_pkg::PSWR_IDLE;
            else if (rise && last_bit) next_state = pswr_pkg::PSWR_TAIL;
         end
         pswr_pkg::PSWR_TAIL: begin
            if (abort) next_state = pswr_pkg::PSWR_IDLE;
            else if (!driving && !line_in) next_state = pswr_pkg::PSWR_IDLE;
         end
         default: next_state = pswr_pkg::PSWR_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         line_q <= 1'b0;
         low_cnt <= '0;
      end else if (ce) begin
         line_q <= line_in;
         low_cnt <= line_in ? '0 : low_cnt + 1'b1;
      end
   end

   // samples are held so a packet is never torn by a mid-transfer update
   always_ff @(posedge clk) begin
      if (!nrst) begin
         first_hold <= 14'h0000;
         second_hold <= 14'h0000;
         temp_hold <= 14'h0000;
      end else if (ce && sample_valid) begin
         first_hold <= first_channel;
         second_hold <= second_channel;
         temp_hold <= temperature;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= pswr_pkg::PSWR_IDLE;
         cnt <= '0;
      end else if (ce) begin
         state <= next_state;
         // counter restarts at each state change; in idle it is the request timer
         cnt <= (next_state != state) ? '0 : cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         packet <= '0;
         idx <= pswr_pkg::LAST_BIT;
      end else if (ce) begin
         if (enter_shift) begin
            packet <= snapshot;
            idx <= pswr_pkg::LAST_BIT;
         end else if (state == pswr_pkg::PSWR_SHIFT && rise && !last_bit) begin
            idx <= idx - 1'b1;
         end
      end
   end

   // a zero is held only for the settle time, then the line is released
   // so a host edge for the next bit never fights the device
   always_ff @(posedge clk) begin
      if (!nrst) begin
         line_out <= 1'b0;
         line_oe_n <= 1'b1;
         drive_cnt <= '0;
      end else if (ce) begin
         if (next_state == pswr_pkg::PSWR_REQ) begin
            line_out <= 1'b1;
            line_oe_n <= 1'b0;
         end else if (state == pswr_pkg::PSWR_SHIFT && rise && !abort) begin
            line_out <= 1'b0;
            line_oe_n <= cur_bit;
            drive_cnt <= '0;
         end else if (driving && state != pswr_pkg::PSWR_REQ) begin
            drive_cnt <= drive_cnt + 1'b1;
            if (drive_cnt >= settle_cyc - 1'b1 || next_state == pswr_pkg::PSWR_IDLE) begin
               line_oe_n <= 1'b1;
            end
         end else begin
            line_oe_n <= 1'b1;
            line_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy <= 1'b0;
      end else if (ce) begin
         busy <= (next_state == pswr_pkg::PSWR_SHIFT) || (next_state == pswr_pkg::PSWR_TAIL);
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_dis
         pswr_discharge #(.DISCHARGE_CYC(DISCHARGE_CYC)) u_dis (
            .clk(clk),
            .nrst(nrst),
            .ce(ce),
            .sample_valid(sample_valid),
            .sample(g == 0 ? first_channel : second_channel),
            .short_input(short_input[g])
         );
      end
   endgenerate

   property p_zero_bit;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_SHIFT && rise && !abort && !cur_bit)
            |=> (!line_oe_n && !line_out);
   endproperty
   a_zero_bit: assert property (p_zero_bit) else $error("zero bit not driven low");

   property p_one_bit;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_SHIFT && rise && !abort && cur_bit) |=> line_oe_n;
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("one bit not released");

   property p_request;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_IDLE && timeout && !rise)
            |=> (state == pswr_pkg::PSWR_REQ && !line_oe_n && line_out);
   endproperty
   a_request: assert property (p_request) else $error("no device request after idle");

   property p_abort;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_SHIFT && abort) |=> state == pswr_pkg::PSWR_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("long low did not abort");

   property p_short_start;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_HSTART && !line_in && !start_long)
            |=> state == pswr_pkg::PSWR_IDLE;
   endproperty
   a_short_start: assert property (p_short_start) else $error("short start accepted");

   property p_good_start;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_HSTART && !line_in && start_long)
            |=> (state == pswr_pkg::PSWR_SHIFT && idx == pswr_pkg::LAST_BIT);
   endproperty
   a_good_start: assert property (p_good_start) else $error("valid start refused");

   property p_last;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_SHIFT && rise && !abort && last_bit)
            |=> state == pswr_pkg::PSWR_TAIL;
   endproperty
   a_last: assert property (p_last) else $error("packet did not end at bit zero");

   property p_pack;
      @(posedge clk) disable iff (!nrst)
         (ce && enter_shift && !sample_valid) |=>
            (packet[41:28] == $past(second_hold) && packet[27:14] == $past(first_hold)
             && packet[13:0] == $past(temp_hold));
   endproperty
   a_pack: assert property (p_pack) else $error("packet layout wrong");

   property p_step;
      @(posedge clk) disable iff (!nrst)
         (ce && state == pswr_pkg::PSWR_SHIFT && rise && !abort && !last_bit)
            |=> idx == $past(idx) - 6'h01;
   endproperty
   a_step: assert property (p_step) else $error("bit index not stepped");
endmodule

/* File: tb/pswr_host_model.sv */
// host side model of the single wire readout link
`timescale 1ns/1ps
module pswr_host_model (
   // clock
   input wire logic clk,
   // shared line
   input wire logic line_lvl,
   output logic host_drv,
   output logic host_lvl,
   // received packet
   output logic [41:0] rx,
   output logic done
);
   // sample 100 cycles in, inside the 2 us settle, rest until the device lets go of a zero
   localparam int SETTLE_CYC = 100;
   localparam int REST_CYC = 160;
   // scaled stand-in for the request wait; the device does not time it
   localparam int REQ_WAIT_CYC = 30;
   initial begin
      host_drv = 1'b0;
      host_lvl = 1'b0;
      rx = '0;
      done = 1'b0;
   end
   task automatic drive(input logic v, input int n);
      host_drv = 1'b1;
      host_lvl = v;
      repeat (n) @(negedge clk);
   endtask
   task automatic start_forced(input int hold);
      drive(1'b1, hold);
      drive(1'b0, 4);
   endtask
   task automatic get_bit(output logic b);
      drive(1'b1, 2);
      host_drv = 1'b0;
      repeat (SETTLE_CYC) @(negedge clk);
      b = line_lvl;
      repeat (REST_CYC) @(negedge clk);
      drive(1'b0, 5);
   endtask
   task automatic read_bits(input int n);
      logic b;
      for (int i = 0; i < n; i++) begin
         get_bit(b);
         rx = {rx[40:0], b};
      end
   endtask
   task automatic finish();
      drive(1'b0, 70);
      host_drv = 1'b0;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask
   task automatic wait_request(output int cnt);
      host_drv = 1'b0;
      cnt = 0;
      while (line_lvl !== 1'b1 && cnt < 3000) begin
         @(negedge clk);
         cnt++;
      end
      if (line_lvl !== 1'b1) cnt = 0;
      repeat (REQ_WAIT_CYC) @(negedge clk);
      drive(1'b0, 4);
   endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the pyro sensor single wire readout device end
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   logic clk, nrst, ce, sample_valid, line_out, line_oe_n, busy, host_drv, host_lvl, done;
   logic [13:0] first_channel, second_channel, temperature;
   logic [1:0] short_input;
   logic [41:0] rx, got;
   logic line_lvl = 1'b0;
   logic [41:0] exp_q[$];
   integer seed = 35;
   int num_errors = 0;
   int compares = 0;
   int cnt;
   pswr_top #(.START_HOLD_CYC(20), .SAMPLE_PERIOD_CYC(2000), .ABORT_LOW_CYC(400),
      .DISCHARGE_CYC(100)) pswr_top_i (.clk(clk), .nrst(nrst), .ce(ce),
      .sample_valid(sample_valid), .first_channel(first_channel),
      .second_channel(second_channel), .temperature(temperature), .line_in(line_lvl),
      .line_out(line_out), .line_oe_n(line_oe_n), .short_input(short_input), .busy(busy));
   pswr_host_model pswr_host_model_i (.clk(clk), .line_lvl(line_lvl), .host_drv(host_drv),
      .host_lvl(host_lvl), .rx(rx), .done(done));
   // no pull on the line: a released line keeps its last level
   always @(line_oe_n or line_out or host_drv or host_lvl) begin
      if (line_oe_n === 1'b0) line_lvl = line_out;
      else if (host_drv === 1'b1) line_lvl = host_lvl;
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      if (exp_q.size() != 0) num_errors++;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic load(input int k, input bit note);
      sample_valid = 1'b1;
      second_channel = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0000 : 14'($random(seed));
      first_channel = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0000 : 14'($random(seed));
      temperature = (k == 1) ? 14'h3fff : 14'($random(seed));
      if (note) exp_q.push_back({second_channel, first_channel, temperature});
      @(negedge clk);
      sample_valid = 1'b0;
   endtask
   task automatic full_read();
      pswr_host_model_i.start_forced(30);
      pswr_host_model_i.read_bits(42);
      pswr_host_model_i.finish();
   endtask
   task automatic dis_case(input logic [13:0] a, input logic [13:0] b, input logic [1:0] e);
      sample_valid = 1'b1;
      first_channel = a;
      second_channel = b;
      @(negedge clk);
      sample_valid = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(short_input, e)
      repeat (110) @(negedge clk);
      `CHK(short_input, 2'b00)
   endtask
   // ce low must drop a sample and stretch the discharge by the frozen cycles
   task automatic ce_case(input int hold);
      second_channel = 14'h2000;
      first_channel = 14'h0000;
      sample_valid = 1'b1;
      ce = 1'b0;
      @(negedge clk);
      ce = 1'b1;
      `CHK(short_input, 2'b00)
      @(negedge clk);
      sample_valid = 1'b0;
      ce = 1'b0;
      repeat (hold) @(negedge clk);
      `CHK(short_input, 2'b01)
      ce = 1'b1;
      repeat (90) @(negedge clk);
      `CHK(short_input, 2'b01)
      repeat (20) @(negedge clk);
      `CHK(short_input, 2'b00)
   endtask
   // result watcher takes the oldest note for each finished packet
   initial begin
      forever begin
         // done stands from one falling edge to the next, so one rising edge sees it once
         @(posedge clk);
         if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
               num_errors++;
               $display("wrong value at %0t: packet without a note", $time);
            end else begin
               got = exp_q.pop_front();
               `CHK(rx, got)
            end
         end
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      $display("wrong value at %0t: run limit reached", $time);
      wrap_up();
   end
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      sample_valid = 1'b0;
      first_channel = 14'h0000;
      second_channel = 14'h0000;
      temperature = 14'h0000;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      pswr_host_model_i.start_forced(10);
      repeat (20) @(negedge clk);
      `CHK(busy, 1'b0)
      $display("test short start done");
      for (int k = 0; k < 4; k++) begin
         load(k, 1'b1);
         full_read();
      end
      $display("test forced readout done");
      load(2, 1'b1);
      pswr_host_model_i.start_forced(30);
      pswr_host_model_i.read_bits(5);
      `CHK(busy, 1'b1)
      pswr_host_model_i.drive(1'b0, 450);
      `CHK(busy, 1'b0)
      full_read();
      $display("test abort done");
      load(3, 1'b1);
      pswr_host_model_i.wait_request(cnt);
      `CHK(cnt >= 1900 && cnt <= 2100, 1'b1)
      pswr_host_model_i.read_bits(42);
      pswr_host_model_i.finish();
      $display("test device request done");
      temperature = 14'($random(seed));
      dis_case(14'h01fe, 14'h2000, 2'b01);
      dis_case(14'h01ff, 14'h3e00, 2'b00);
      dis_case(14'h1f40, 14'h3e01, 2'b10);
      dis_case(14'h0000, 14'h3fff, 2'b11);
      $display("test discharge done");
      ce_case(10 + ($random(seed) & 15));
      $display("test clock enable done");
      sample_valid = 1'b1;
      first_channel = 14'h3fff;
      @(negedge clk);
      sample_valid = 1'b0;
      `CHK(short_input, 2'b01)
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({short_input, busy, line_oe_n}, 4'b0001)
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      `CHK({short_input, busy, line_oe_n}, 4'b0001)
      $display("test reset done");
      repeat (5) @(negedge clk);
      wrap_up();
   end
endmodule
